// file: hdl/fcs_regs.svh
// command codes, status bit positions and timing counts for the flash host
`ifndef FCS_REGS_SVH
`define FCS_REGS_SVH

`define FCS_CMD_BUF_SETUP 8'he8
`define FCS_CMD_LOCK_SETUP 8'h60
`define FCS_CMD_LOCK_SET 8'h01
`define FCS_CMD_CONFIRM 8'hd0
`define FCS_CMD_READ_ARRAY 8'hff
`define FCS_CMD_CLR_STATUS 8'h50
`define FCS_CMD_READ_STATUS 8'h70

`define FCS_MACHINE_READY_BIT 7
`define FCS_BUFFER_READY_BIT 7
`define FCS_ERASE_ERROR_BIT 5
`define FCS_WRITE_ERROR_BIT 4
`define FCS_SUPPLY_ERROR_BIT 3
`define FCS_PROTECT_DETECT_BIT 1
`define FCS_ERR_MASK 8'h3a

`define FCS_ADDR_W 21
`define FCS_BLOCK_LSB 16
`define FCS_BUF_LSB 5
`define FCS_COUNT_W 5

`define FCS_CLK_NS 40
`define FCS_T_WP_NS 50
`define FCS_T_ACC_NS 100
`define FCS_T_WAKE_NS 1000
`define FCS_WP_CYC ((`FCS_T_WP_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ACC_CYC ((`FCS_T_ACC_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_SYNC_CYC 2
`define FCS_WAKE_CYC ((`FCS_T_WAKE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

// file: hdl/fcs_pkg.sv
// types shared by the flash command host
package fcs_pkg;
    typedef enum logic [2:0] {
        FCS_OP_BUF_WRITE,
        FCS_OP_SET_LOCK,
        FCS_OP_CLR_LOCKS,
        FCS_OP_READ_ARRAY,
        FCS_OP_CLR_STATUS
    } fcs_op_t;
endpackage : fcs_pkg

// file: hdl/fcs_bus_cycle.sv
// one asynchronous sram-style write or read cycle on the flash pins
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.svh"
module fcs_bus_cycle
    import fcs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic abort,
    input wire logic start,
    input wire logic is_write,
    input wire logic [`FCS_ADDR_W-1:0] addr_in,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    output logic [`FCS_ADDR_W-1:0] flash_addr,
    output logic [7:0] flash_dq_out,
    input wire logic [7:0] flash_dq_in,
    output logic flash_dq_oe_n,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n
);
    typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} fcs_cyc_t;
    fcs_cyc_t state;
    logic wr;
    logic [3:0] cnt;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dq_s1 <= 8'h00;
            dq_s2 <= 8'h00;
        end else begin
            dq_s1 <= flash_dq_in;
            dq_s2 <= dq_s1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= C_IDLE;
            cnt <= 4'h0;
            wr <= 1'b0;
            flash_addr <= '0;
            flash_dq_out <= 8'h00;
        end else if (abort) begin
            state <= C_IDLE;
        end else begin
            unique case (state)
                C_IDLE: if (start) begin
                    state <= C_SETUP;
                    wr <= is_write;
                    flash_addr <= addr_in;
                    flash_dq_out <= wdata;
                end
                C_SETUP: begin
                    state <= C_PULSE;
                    // reads wait for access time plus the input synchroniser
                    cnt <= wr ? 4'(`FCS_WP_CYC - 1)
                              : 4'(`FCS_ACC_CYC + `FCS_SYNC_CYC - 1);
                end
                C_PULSE: if (cnt == 4'h0) begin
                    state <= C_HOLD;
                end else begin
                    cnt <= cnt - 4'h1;
                end
                C_HOLD: state <= C_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (state == C_PULSE && cnt == 4'h0 && !wr) begin
            rdata <= dq_s2;
        end
    end

    // a write takes effect only with both strobes low together
    assign flash_ce_n = (state == C_IDLE);
    assign flash_we_n = !(state == C_PULSE && wr);
    assign flash_oe_n = !(state == C_PULSE && !wr);
    assign flash_dq_oe_n = !(state != C_IDLE && wr);
    assign done = (state == C_HOLD) && !abort;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_we_with_ce: assert property (!flash_we_n |-> !flash_ce_n)
        else $error("write strobe low without chip enable");
    chk_write_pulse: assert property ($fell(flash_we_n) |->
        !flash_we_n[*2] ##1 (flash_we_n && !flash_ce_n && !flash_dq_oe_n))
        else $error("write pulse length or hold wrong");
    chk_no_fight: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n)
        else $error("data driven during a read");
endmodule : fcs_bus_cycle
`default_nettype wire

// file: hdl/fcs_host.sv
// host controller sequencing flash commands through the parallel pins
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.svh"
module fcs_host
    import fcs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic req,
    input wire fcs_op_t op,
    input wire logic [`FCS_ADDR_W-1:0] addr,
    input wire logic [`FCS_COUNT_W-1:0] count_m1,
    input wire logic [7:0] wdata,
    input wire logic wdata_valid,
    output logic wdata_ready,
    input wire logic pd_req,
    output logic busy,
    output logic done,
    output logic [7:0] status,
    output logic seq_error,
    output logic aborted,
    output logic misaligned,
    output logic [`FCS_ADDR_W-1:0] flash_addr,
    output logic [7:0] flash_dq_out,
    input wire logic [7:0] flash_dq_in,
    output logic flash_dq_oe_n,
    output logic flash_ce_n,
    output logic flash_we_n,
    output logic flash_oe_n,
    output logic reset_powerdown_in,
    input wire logic completion_output
);
    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_BUF_CHK, S_COUNT, S_DATA, S_CONFIRM,
        S_POLL, S_CLEAR, S_ARRAY, S_DONE, S_PD, S_WAKE
    } fcs_state_t;

    fcs_state_t state;
    fcs_op_t cur_op;
    logic [`FCS_ADDR_W-1:0] start_addr;
    logic [`FCS_ADDR_W-1:0] cur_addr;
    logic [`FCS_COUNT_W-1:0] count;
    logic [`FCS_COUNT_W-1:0] left;
    logic [9:0] wake_cnt;
    logic pend;
    logic cmp_s1;
    logic cmp_s2;
    logic bc_start;
    logic bc_done;
    logic bc_write;
    logic [`FCS_ADDR_W-1:0] bc_addr;
    logic [7:0] bc_wdata;
    logic [7:0] bc_rdata;
    logic cyc_want;

    function automatic logic [7:0] setup_code(input fcs_op_t o);
        unique case (o)
            FCS_OP_BUF_WRITE: setup_code = `FCS_CMD_BUF_SETUP;
            FCS_OP_SET_LOCK, FCS_OP_CLR_LOCKS: setup_code = `FCS_CMD_LOCK_SETUP;
            FCS_OP_READ_ARRAY: setup_code = `FCS_CMD_READ_ARRAY;
            FCS_OP_CLR_STATUS: setup_code = `FCS_CMD_CLR_STATUS;
            default: setup_code = `FCS_CMD_READ_STATUS;
        endcase
    endfunction : setup_code

    // completion pin is open drain with a pull-up, so it is a foreign level
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
        end else begin
            cmp_s1 <= completion_output;
            cmp_s2 <= cmp_s1;
        end
    end

    always_comb begin
        cyc_want = 1'b1;
        bc_write = 1'b1;
        bc_addr = start_addr;
        bc_wdata = `FCS_CMD_READ_ARRAY;
        unique case (state)
            S_SETUP: bc_wdata = setup_code(cur_op);
            S_BUF_CHK: bc_write = 1'b0;
            S_COUNT: bc_wdata = {3'h0, count};
            S_DATA: begin
                cyc_want = wdata_valid;
                bc_addr = cur_addr;
                bc_wdata = wdata;
            end
            S_CONFIRM: bc_wdata = (cur_op == FCS_OP_SET_LOCK) ?
                `FCS_CMD_LOCK_SET : `FCS_CMD_CONFIRM;
            S_POLL: begin
                // the pin releases when the machine finishes
                cyc_want = cmp_s2;
                bc_write = 1'b0;
            end
            S_CLEAR: bc_wdata = `FCS_CMD_CLR_STATUS;
            S_ARRAY: bc_wdata = `FCS_CMD_READ_ARRAY;
            S_IDLE, S_DONE, S_PD, S_WAKE: cyc_want = 1'b0;
        endcase
    end

    assign bc_start = cyc_want && !pend && !pd_req;
    assign wdata_ready = (state == S_DATA) && bc_start;
    assign busy = (state != S_IDLE);
    assign done = (state == S_DONE);
    assign seq_error = status[`FCS_ERASE_ERROR_BIT] &&
        status[`FCS_WRITE_ERROR_BIT];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pend <= 1'b0;
        end else if (pd_req || bc_done) begin
            pend <= 1'b0;
        end else if (bc_start) begin
            pend <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= S_IDLE;
            cur_op <= FCS_OP_READ_ARRAY;
            start_addr <= '0;
            cur_addr <= '0;
            count <= '0;
            left <= '0;
            wake_cnt <= 10'h000;
        end else if (pd_req) begin
            state <= S_PD;
        end else begin
            unique case (state)
                S_IDLE: if (req) begin
                    state <= S_SETUP;
                    cur_op <= op;
                    start_addr <= addr;
                    cur_addr <= addr;
                    count <= count_m1;
                    left <= count_m1;
                end
                S_SETUP: if (bc_done) begin
                    unique case (cur_op)
                        FCS_OP_BUF_WRITE: state <= S_BUF_CHK;
                        FCS_OP_SET_LOCK, FCS_OP_CLR_LOCKS: state <= S_CONFIRM;
                        default: state <= S_DONE;
                    endcase
                end
                S_BUF_CHK: if (bc_done) begin
                    // buffer busy: reissue the setup and look again
                    state <= bc_rdata[`FCS_BUFFER_READY_BIT] ? S_COUNT : S_SETUP;
                end
                S_COUNT: if (bc_done) state <= S_DATA;
                S_DATA: if (bc_done) begin
                    if (left == '0) begin
                        state <= S_CONFIRM;
                    end else begin
                        left <= left - 1'b1;
                        cur_addr <= cur_addr + 1'b1;
                    end
                end
                S_CONFIRM: if (bc_done) state <= S_POLL;
                S_POLL: if (bc_done && bc_rdata[`FCS_MACHINE_READY_BIT]) begin
                    // any sticky error is cleared before returning to reads
                    state <= ((bc_rdata & `FCS_ERR_MASK) != 8'h00) ?
                        S_CLEAR : S_ARRAY;
                end
                S_CLEAR: if (bc_done) state <= S_ARRAY;
                S_ARRAY: if (bc_done) state <= S_DONE;
                S_DONE: state <= S_IDLE;
                S_PD: begin
                    state <= S_WAKE;
                    wake_cnt <= 10'(`FCS_WAKE_CYC);
                end
                S_WAKE: if (wake_cnt == 10'h000) begin
                    state <= S_IDLE;
                end else begin
                    wake_cnt <= wake_cnt - 10'h001;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status <= 8'h00;
            aborted <= 1'b0;
            misaligned <= 1'b0;
            reset_powerdown_in <= 1'b0;
        end else begin
            reset_powerdown_in <= !pd_req;
            if (pd_req) begin
                status <= 8'h00;
                if (state != S_IDLE && state != S_PD && state != S_WAKE) begin
                    aborted <= 1'b1;
                end
            end else if (state == S_IDLE && req) begin
                aborted <= 1'b0;
                misaligned <= (op == FCS_OP_BUF_WRITE) &&
                    (addr[`FCS_BUF_LSB-1:0] != '0);
            end else if (state == S_POLL && bc_done &&
                         bc_rdata[`FCS_MACHINE_READY_BIT]) begin
                status <= bc_rdata;
            end
        end
    end

    fcs_bus_cycle u_cycle (
        .clk(clk),
        .rstn(rstn),
        .abort(pd_req),
        .start(bc_start),
        .is_write(bc_write),
        .addr_in(bc_addr),
        .wdata(bc_wdata),
        .done(bc_done),
        .rdata(bc_rdata),
        .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out),
        .flash_dq_in(flash_dq_in),
        .flash_dq_oe_n(flash_dq_oe_n),
        .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n),
        .flash_oe_n(flash_oe_n)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_count_first: assert property (state == S_COUNT && bc_start |->
        bc_wdata == {3'h0, count} && bc_addr == start_addr)
        else $error("count write wrong");
    chk_data_addr: assert property (state == S_DATA && bc_start |->
        bc_addr == start_addr + `FCS_ADDR_W'(count - left))
        else $error("data write address out of sequence");
    chk_clear_after_err: assert property (state == S_POLL && bc_done &&
        bc_rdata[`FCS_MACHINE_READY_BIT] && !pd_req &&
        (bc_rdata & `FCS_ERR_MASK) != 8'h00 |=> state == S_CLEAR)
        else $error("error not cleared");
    chk_array_after: assert property (state == S_CLEAR && bc_done &&
        !pd_req |=> state == S_ARRAY ##[1:12] (state == S_DONE))
        else $error("read array not issued");
    chk_lock_confirm: assert property (state == S_CONFIRM && bc_start &&
        cur_op == FCS_OP_SET_LOCK |-> bc_wdata == `FCS_CMD_LOCK_SET)
        else $error("lock confirm code wrong");
    chk_unlock_confirm: assert property (state == S_CONFIRM &&
        bc_start && cur_op == FCS_OP_CLR_LOCKS |->
        bc_wdata == `FCS_CMD_CONFIRM)
        else $error("unlock confirm code wrong");
    chk_pd_pin: assert property (pd_req |=> !reset_powerdown_in &&
        status == 8'h00 && state == S_PD)
        else $error("power-down not applied");
    chk_seq_flag: assert property (seq_error |->
        status[`FCS_ERASE_ERROR_BIT] && status[`FCS_WRITE_ERROR_BIT])
        else $error("sequence error flag wrong");
    // while polling, a low completion pin must keep the flash bus idle
    chk_poll_gate: assert property (state == S_POLL && !cmp_s2 &&
        !pend |=> flash_ce_n)
        else $error("polled while completion pin low");
endmodule : fcs_host
`default_nettype wire

// file: tb/fcs_flash_model.sv
// behavioural model of the parallel flash device seen by the host
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.svh"
module fcs_flash_model (
    input wire logic clk,
    input wire logic [`FCS_ADDR_W-1:0] flash_addr,
    input wire logic [7:0] flash_dq_out,
    input wire logic flash_ce_n,
    input wire logic flash_we_n,
    input wire logic flash_oe_n,
    input wire logic reset_powerdown_in,
    input wire logic slow,
    input wire logic op_fail,
    input wire logic vpp_bad,
    output logic [7:0] dq_rd,
    output logic dq_rd_oe_n,
    output logic cmp_oe_n
);
    // mode: 0 array, 1 status, 2 count next, 4 data, 5 confirm, 6 lock
    logic [2:0] mode;
    logic [5:0] err;
    logic [6:0] busy_cnt;
    logic [4:0] left;
    logic [4:0] loaded;
    logic [`FCS_ADDR_W-1:0] start;
    logic [`FCS_ADDR_W-1:0] prog_addr;
    logic bad_blk;
    logic we_q;
    logic [7:0] last_rd;
    logic [7:0] val;
    int setups;

    function automatic logic [5:0] fault(input int b);
        return ((op_fail || vpp_bad) ? 6'(1 << b) : 6'h00)
            | (vpp_bad ? 6'h08 : 6'h00);
    endfunction : fault

    always @(posedge clk or negedge reset_powerdown_in) begin
        if (!reset_powerdown_in) begin
            mode <= 3'h0;
            err <= 6'h00;
            busy_cnt <= 7'h00;
            we_q <= 1'b1;
        end else begin
            we_q <= flash_we_n;
            if (busy_cnt != 0) begin
                busy_cnt <= busy_cnt - 7'h01;
            end
            if (!we_q && flash_we_n && !flash_ce_n) begin
                case (mode)
                3'h2: if (flash_dq_out == `FCS_CMD_BUF_SETUP) begin
                    // setup repeated after a busy buffer report
                    setups <= setups + 1;
                end else begin
                    left <= flash_dq_out[4:0];
                    loaded <= flash_dq_out[4:0];
                    mode <= 3'h4;
                end
                3'h4: begin
                    if (flash_addr[`FCS_ADDR_W-1:`FCS_BLOCK_LSB]
                        != start[`FCS_ADDR_W-1:`FCS_BLOCK_LSB]) begin
                        bad_blk <= 1'b1;
                    end
                    if (left == 0) begin
                        mode <= 3'h5;
                    end
                    left <= left - 5'h01;
                end
                3'h5, 3'h6: begin
                    mode <= 3'h1;
                    busy_cnt <= slow ? 7'h3c : 7'h04;
                    if (mode == 3'h5 && !bad_blk
                        && flash_dq_out == `FCS_CMD_CONFIRM) begin
                        prog_addr <= start;
                        err <= err | fault(4);
                    end else if (mode == 3'h6
                        && flash_dq_out == `FCS_CMD_LOCK_SET) begin
                        err <= err | fault(4);
                    end else if (mode == 3'h6
                        && flash_dq_out == `FCS_CMD_CONFIRM) begin
                        err <= err | fault(5);
                    end else begin
                        err <= err | 6'h30;
                        busy_cnt <= 7'h00;
                    end
                end
                default: begin
                    case (flash_dq_out)
                    `FCS_CMD_BUF_SETUP: begin
                        mode <= 3'h2;
                        start <= flash_addr;
                        bad_blk <= 1'b0;
                        // slow device reports the buffer busy for a while
                        busy_cnt <= slow ? 7'h06 : 7'h00;
                        setups <= setups + 1;
                    end
                    `FCS_CMD_LOCK_SETUP: mode <= 3'h6;
                    `FCS_CMD_CLR_STATUS: err <= 6'h00;
                    `FCS_CMD_READ_STATUS: mode <= 3'h1;
                    `FCS_CMD_READ_ARRAY: mode <= 3'h0;
                    default: mode <= mode;
                    endcase
                end
                endcase
            end
        end
    end

    always_comb begin
        if (mode == 3'h0) begin
            val = flash_addr[7:0] ^ 8'ha5;
        end else if (mode == 3'h2) begin
            val = {busy_cnt == 0, 7'h00};
        end else begin
            val = {busy_cnt == 0, 1'b0, err};
        end
        dq_rd_oe_n = !(!flash_ce_n && !flash_oe_n && reset_powerdown_in);
        // released bus shows the inverse of the last driven value
        dq_rd = dq_rd_oe_n ? ~last_rd : val;
        cmp_oe_n = !(busy_cnt != 0 && reset_powerdown_in);
    end

    always @(posedge clk) begin
        if (!dq_rd_oe_n) begin
            last_rd <= val;
        end
    end
endmodule : fcs_flash_model
`default_nettype wire

// file: tb/fcs_host_tb.sv
// self-checking bench for the flash command host against a device model
`timescale 1ns/1ns
`default_nettype none
`include "fcs_regs.svh"
module fcs_host_tb
    import fcs_pkg::*;
;
    logic clk, rstn, req, wdata_valid, wdata_ready, pd_req, busy, done;
    fcs_op_t op;
    logic [`FCS_ADDR_W-1:0] addr, flash_addr;
    logic [`FCS_COUNT_W-1:0] count_m1;
    logic [7:0] wdata, status, flash_dq_out, flash_dq_in, dq_rd;
    logic seq_error, aborted, misaligned, flash_dq_oe_n, flash_ce_n;
    logic flash_we_n, flash_oe_n, reset_powerdown_in, completion_output;
    logic slow, op_fail, vpp_bad, dq_rd_oe_n, cmp_oe_n;
    int n_mismatch, compares, cycles, n_taken, k;
    fcs_op_t t_op [5] = '{FCS_OP_SET_LOCK, FCS_OP_CLR_LOCKS,
        FCS_OP_SET_LOCK, FCS_OP_CLR_LOCKS, FCS_OP_SET_LOCK};
    logic [7:0] t_exp [5] = '{8'h90, 8'ha0, 8'h98, 8'ha8, 8'h80};

    // open-drain completion pin with a pull-up
    assign completion_output = cmp_oe_n ? 1'b1 : 1'b0;
    assign flash_dq_in = !dq_rd_oe_n ? dq_rd
        : (!flash_dq_oe_n ? flash_dq_out : dq_rd);

    fcs_host uut (.clk(clk), .rstn(rstn), .req(req), .op(op), .addr(addr),
        .count_m1(count_m1), .wdata(wdata), .wdata_valid(wdata_valid),
        .wdata_ready(wdata_ready), .pd_req(pd_req), .busy(busy),
        .done(done), .status(status), .seq_error(seq_error),
        .aborted(aborted), .misaligned(misaligned),
        .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
        .flash_dq_in(flash_dq_in), .flash_dq_oe_n(flash_dq_oe_n),
        .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
        .flash_oe_n(flash_oe_n), .reset_powerdown_in(reset_powerdown_in),
        .completion_output(completion_output));

    fcs_flash_model mdl (.clk(clk), .flash_addr(flash_addr),
        .flash_dq_out(flash_dq_out), .flash_ce_n(flash_ce_n),
        .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
        .reset_powerdown_in(reset_powerdown_in), .slow(slow),
        .op_fail(op_fail), .vpp_bad(vpp_bad), .dq_rd(dq_rd),
        .dq_rd_oe_n(dq_rd_oe_n), .cmp_oe_n(cmp_oe_n));

    always #20 clk = ~clk;

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one user command; streams bytes 30h upward until count_m1+1 taken
    task automatic run(input fcs_op_t o, input logic [20:0] a,
        input logic [4:0] cm1);
        int n;
        logic took;
        n = 0;
        took = 1'b0;
        n_taken = 0;
        @(negedge clk);
        req = 1'b1;
        op = o;
        addr = a;
        count_m1 = cm1;
        wdata = 8'h30;
        wdata_valid = (o == FCS_OP_BUF_WRITE);
        @(negedge clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            if (took) begin
                n_taken++;
                wdata = 8'h30 + 8'(n_taken);
                wdata_valid = (n_taken <= int'(cm1));
            end
            took = wdata_valid && wdata_ready;
            @(negedge clk);
            n++;
        end
        wdata_valid = 1'b0;
        check("done", 1'b1, done);
    endtask : run

    initial begin
        clk = 0; rstn = 0; req = 0; op = FCS_OP_READ_ARRAY; addr = '0;
        count_m1 = '0; wdata = '0; wdata_valid = 0; pd_req = 0; slow = 0;
        op_fail = 0; vpp_bad = 0; n_mismatch = 0; compares = 0; cycles = 0;
        repeat (16) @(negedge clk);
        rstn = 1;
        repeat (30) @(negedge clk);
        check("status", 8'h00, status);
        check("pd pin", 1'b1, reset_powerdown_in);
        run(FCS_OP_READ_ARRAY, 21'h000100, 5'h00);
        check("mode", 3'h0, mdl.mode);
        $display("test read array ended");
        run(FCS_OP_BUF_WRITE, 21'h010020, 5'h1f);
        check("bytes", 32, n_taken);
        check("count", 5'h1f, mdl.loaded);
        check("prog addr", 21'h010020, mdl.prog_addr);
        check("status", 8'h80, status);
        check("misaligned", 1'b0, misaligned);
        check("mode", 3'h0, mdl.mode);
        $display("test buffered write ended");
        slow = 1;
        k = mdl.setups;
        run(FCS_OP_BUF_WRITE, 21'h01fffe, 5'h03);
        check("setup retry", k + 2, mdl.setups);
        check("status", 8'hb0, status);
        check("seq error", 1'b1, seq_error);
        check("misaligned", 1'b1, misaligned);
        check("model err", 6'h00, mdl.err);
        $display("test block crossing ended");
        for (k = 0; k < 5; k++) begin
            op_fail = (k < 2);
            vpp_bad = (k == 2 || k == 3);
            slow = (k == 4);
            run(t_op[k], 21'h030000, 5'h00);
            repeat (5) @(negedge clk);
            check("status", t_exp[k], status);
            check("mode", 3'h0, mdl.mode);
        end
        op_fail = 0;
        vpp_bad = 0;
        run(FCS_OP_CLR_STATUS, 21'h000000, 5'h00);
        check("model err", 6'h00, mdl.err);
        $display("test lock bits ended");
        @(negedge clk);
        req = 1'b1;
        op = FCS_OP_SET_LOCK;
        @(negedge clk);
        req = 1'b0;
        repeat (20) @(negedge clk);
        check("busy", 1'b1, busy);
        pd_req = 1'b1;
        @(negedge clk);
        check("pd pin", 1'b0, reset_powerdown_in);
        check("completion", 1'b1, completion_output);
        check("status", 8'h00, status);
        check("aborted", 1'b1, aborted);
        repeat (3) @(negedge clk);
        pd_req = 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 100) begin
            @(negedge clk);
            k++;
        end
        check("busy", 1'b0, busy);
        check("mode", 3'h0, mdl.mode);
        slow = 0;
        run(FCS_OP_SET_LOCK, 21'h030000, 5'h00);
        check("status", 8'h80, status);
        check("aborted", 1'b0, aborted);
        $display("test power-down abort ended");
        stop_test();
    end
endmodule : fcs_host_tb
`default_nettype wire
